// >>> rtl/sram_host_map.svh
// constants for the host-side controller of a 4096 x 4 asynchronous static memory
// assumes a 125 MHz system clock; times in ns, cycle counts derived from them
// How it works
// - write only while select and write low
// - write ends at first rising strobe
// - read: write high, select low
// - host never fights memory-driven pins
// - no conflicting write data while memory drives
// - select low 40 ns before write end
// - address stable 40 ns before write end
// - write data valid 20 ns before end
// - retention: deselect first, wait read cycle
`ifndef SRAM_HOST_MAP_SVH
`define SRAM_HOST_MAP_SVH
`define CLK_PERIOD_PS 8000
// slowest grade figures, so the controller suits every grade
`define T_WRITE_OVERLAP_NS 35
`define T_SELECT_TO_END_NS 40
`define T_ADDR_TO_END_NS 40
`define T_DATA_TO_END_NS 20
`define T_ACCESS_NS 45
`define T_OUT_FLOAT_NS 20
`define T_WRITE_RECOVERY_NS 0
// least times round up
`define CYC_UP(ns) (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_WRITE `CYC_UP(`T_ADDR_TO_END_NS)
`define CYC_ACCESS `CYC_UP(`T_ACCESS_NS)
`define CYC_FLOAT `CYC_UP(`T_OUT_FLOAT_NS)
`endif

// >>> rtl/sram_host_pkg.sv
// types for the host-side static memory controller
// assumes the map header supplies all constants
package sram_host_pkg;
    // user request: address, data, direction
    typedef struct packed {
        logic [11:0] addr;
        logic [3:0] data;
        logic write;
    } sram_req_t;
    // controller states, gray along idle-wstrobe-wend-rwait-turn in code order
    typedef enum logic [2:0] {
        IDLE = 3'b000,
        WSTROBE = 3'b001,
        WEND = 3'b011,
        RWAIT = 3'b010,
        TURN = 3'b110
    } sram_state_t;
endpackage

// >>> rtl/sram_host.sv
// host controller driving a 4096 x 4 asynchronous static memory over its pins
// assumes memory pins are synchronous to clk_sys and the bench resolves the data wire
`timescale 1ns/1ps
`include "sram_host_map.svh"
module sram_host #(
    parameter int WRITE_CYCLES = `CYC_WRITE,
    parameter int ACCESS_CYCLES = `CYC_ACCESS,
    parameter int FLOAT_CYCLES = `CYC_FLOAT
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire sram_host_pkg::sram_req_t reqIn,
    input wire logic reqValid,
    output logic reqReady,
    output logic [3:0] readData,
    output logic readValid,
    output logic retentionReady,
    input wire logic retentionReq,
    output logic [11:0] memAddr,
    output logic memSelect_n,
    output logic memWrite_n,
    input wire logic [3:0] memDataIn,
    output logic [3:0] memDataOut,
    output logic memDataOe
);
    import sram_host_pkg::*;

    // reset release
    // the pin clears the chain at once; the far flop lets go two edges after the pin rises,
    // so every process on rstN leaves reset on one clean edge
    logic [1:0] resetSync; // release sync chain
    wire rstN = resetSync[1]; // internal reset, active low

    // sequencer state
    sram_state_t state; // phase of the pin sequence now
    sram_state_t next_state; // phase for the coming edge
    logic [7:0] count; // cycles left in current phase
    logic [7:0] next_count; // count for the coming edge
    logic retention; // held deselected for low supply

    // count loads sit one below the phase length, because a phase ends on its zero cycle
    wire [7:0] writeLoad = 8'(WRITE_CYCLES - 1); // strobes low for WRITE_CYCLES edges
    wire [7:0] accessLoad = 8'(ACCESS_CYCLES - 1); // select low for ACCESS_CYCLES edges before sampling
    wire [7:0] floatLoad = 8'(FLOAT_CYCLES - 1); // quiet pins after a read
    wire [7:0] countDown = count - 8'h01; // next value while a phase runs

    // state decode
    wire inIdle = (state == IDLE); // free for a request or a retention change
    wire inStrobe = (state == WSTROBE); // select and write strobe low
    wire inWriteEnd = (state == WEND); // strobes high, write data still driven
    wire inReadWait = (state == RWAIT); // select low, waiting out the access time
    wire inTurn = (state == TURN); // select high, memory outputs floating
    wire countDone = (count == 8'h00); // last cycle of the running phase

    // request and retention decode; the three idle actions exclude one another
    wire enterRetention = inIdle && retentionReq && !retention;
    wire leaveRetention = inIdle && !retentionReq && retention;
    wire takeReq = inIdle && reqValid && !retention && !retentionReq; // refused during retention
    wire takeWrite = takeReq && reqIn.write;
    wire takeRead = takeReq && !reqIn.write;
    wire strobeEnd = inStrobe && countDone;
    wire readSample = inReadWait && countDone;
    wire turnDone = inTurn && countDone;

    // reset release through two flops
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            resetSync <= 2'h0; // chain empty, internal reset held
        end else begin
            resetSync <= {resetSync[0], 1'b1}; // fill one stage per edge
        end
    end

    // next phase and count
    // a phase of N cycles loads N-1 and ends on the edge that sees zero
    always_comb begin
        next_state = state;
        next_count = count;
        unique case (state)
            IDLE: begin
                // retention entry changes no phase; exit waits one access time on quiet pins
                if (leaveRetention) begin
                    next_state = TURN;
                    next_count = accessLoad;
                end else if (takeWrite) begin
                    next_state = WSTROBE; // strobes fall at this edge
                    next_count = writeLoad;
                end else if (takeRead) begin
                    next_state = RWAIT; // select falls at this edge
                    next_count = accessLoad;
                end
            end
            WSTROBE: begin
                // the slowest figures set the length, so select, address and data all fit
                if (strobeEnd) begin
                    next_state = WEND; // strobes rise together
                end else begin
                    next_count = countDown; // keep counting the overlap
                end
            end
            WEND: begin
                // one cycle of data hold after the strobes rise
                next_state = IDLE;
            end
            RWAIT: begin
                // sample only once access time has passed
                if (readSample) begin
                    next_state = TURN; // select rises with the sample
                    next_count = floatLoad;
                end else begin
                    next_count = countDown; // access time still running
                end
            end
            TURN: begin
                // let memory outputs float before any host drive
                if (turnDone) begin
                    next_state = IDLE;
                end else begin
                    next_count = countDown; // pins still settling
                end
            end
            default: begin
                // an illegal code returns to idle with the strobes as they are
                next_state = IDLE;
            end
        endcase
    end

    // state and count registers
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            state <= IDLE;
            count <= 8'h00;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // chip select: falls at every take, rises after the strobe phase or at the read sample
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            memSelect_n <= 1'b1; // deselected, memory in standby
        end else if (takeReq) begin
            memSelect_n <= 1'b0;
        end else if (strobeEnd || readSample) begin
            memSelect_n <= 1'b1;
        end
    end

    // write strobe: falls with select, so the memory never turns its outputs on in a write
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            memWrite_n <= 1'b1; // no write out of reset
        end else if (takeWrite) begin
            memWrite_n <= 1'b0;
        end else if (takeRead || strobeEnd) begin
            memWrite_n <= 1'b1;
        end
    end

    // address: set with select and held to the end of the phase
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            memAddr <= 12'h000;
        end else if (takeReq) begin
            memAddr <= reqIn.addr;
        end
    end

    // write data and its output enable
    // the data stays driven one cycle past the strobe rise; that costs a cycle per write
    // but gives hold time without a second clock phase
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            memDataOut <= 4'h0;
            memDataOe <= 1'b0; // pins released out of reset
        end else if (takeWrite) begin
            memDataOut <= reqIn.data;
            memDataOe <= 1'b1;
        end else if (inWriteEnd) begin
            memDataOe <= 1'b0;
        end
    end

    // request handshake: one pulse on the edge after the take
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            reqReady <= 1'b0;
        end else begin
            reqReady <= takeReq;
        end
    end

    // read result: sampled on the last access cycle, flagged for one cycle, data kept
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            readData <= 4'h0;
            readValid <= 1'b0;
        end else begin
            readValid <= readSample;
            if (readSample) begin
                readData <= memDataIn;
            end
        end
    end

    // retention: the memory is already deselected in idle, so entry only raises the flag;
    // the supply may drop once retentionReady is seen high
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            retention <= 1'b0;
            retentionReady <= 1'b0;
        end else if (enterRetention) begin
            retention <= 1'b1;
            retentionReady <= 1'b1;
        end else if (leaveRetention) begin
            retention <= 1'b0;
            retentionReady <= 1'b0;
        end
    end
endmodule

// >>> verification/sram_host_monitor.sv
// checker on the controller pins, bound into the controller
// assumes the default timing parameters: 5 write, 6 access and 3 float cycles
`timescale 1ns/1ps
module sram_host_monitor(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic memSelect_n,
    input wire logic memWrite_n,
    input wire logic memDataOe,
    input wire logic [11:0] memAddr,
    input wire logic [3:0] memDataOut,
    input wire logic readValid,
    input wire logic retentionReady
);
default clocking @(posedge clk_sys); endclocking
default disable iff (!reset_n);
property p_wide; $fell(memWrite_n) |-> !memWrite_n[*5]; endproperty
a_wide: assert property (p_wide) else $error("write strobe short");
property p_sel; !memWrite_n |-> !memSelect_n; endproperty
a_sel: assert property (p_sel) else $error("write without select");
property p_adr; !memSelect_n && !$past(memSelect_n) |-> $stable(memAddr); endproperty
a_adr: assert property (p_adr) else $error("address moved");
property p_dat; !memWrite_n && !$past(memWrite_n) |-> $stable(memDataOut); endproperty
a_dat: assert property (p_dat) else $error("write data moved");
property p_oe; memDataOe |-> !memWrite_n || !$past(memWrite_n); endproperty
a_oe: assert property (p_oe) else $error("host drives outside write");
property p_rd; !memSelect_n && memWrite_n |-> !memDataOe; endproperty
a_rd: assert property (p_rd) else $error("host drives during read");
property p_acc; $rose(readValid) |-> !$past(memSelect_n, 6) && memWrite_n; endproperty
a_acc: assert property (p_acc) else $error("read sampled early");
property p_ret; retentionReady |-> memSelect_n; endproperty
a_ret: assert property (p_ret) else $error("selected in retention");
property p_flt; $rose(memSelect_n) && $past(memWrite_n) |-> !memDataOe[*3]; endproperty
a_flt: assert property (p_flt) else $error("host drives while memory floats");
property p_rec; $fell(retentionReady) |-> memSelect_n[*6]; endproperty
a_rec: assert property (p_rec) else $error("selected too soon after retention");
endmodule
bind sram_host sram_host_monitor mon(.clk_sys, .reset_n, .memSelect_n, .memWrite_n, .memDataOe,
    .memAddr, .memDataOut, .readValid, .retentionReady);

// >>> verification/sram_model.sv
// memory model on the controller pins: 4096 nibbles with output timing in clock cycles
// assumes pins change just after clk_sys rises; pins show 4'hA while deselected and toggle 4'hA/4'h5 before read data is valid, never the last value
`timescale 1ns/1ps
module sram_model(
    input wire logic clk_sys,
    input wire logic [11:0] memAddr,
    input wire logic memSelect_n,
    input wire logic memWrite_n,
    input wire logic [3:0] pins,
    output logic [3:0] memQ
);
logic [3:0] cells [4096];
int age = 0; // cycles selected for reading; deselect or write restarts it
always @(posedge clk_sys) begin
    if (!memSelect_n && !memWrite_n) cells[memAddr] <= pins;
    // deselect floats the pins and powers down, write low floats them, write end restarts
    age <= (!memSelect_n && memWrite_n) ? age + 1 : 0;
end
// no valid drive early after select; data valid 32 ns after select, inside the 45 ns access;
// the address never moves while selected, so old data is never cut short
assign memQ = (age >= 4) ? cells[memAddr] : {4{age[0]}} ^ 4'hA;
endmodule

// >>> verification/tb.sv
// bench for the host memory controller with the memory model on its pins
// assumes the map header's slowest-grade counts and the controller's default parameters
`timescale 1ns/1ps
`include "sram_host_map.svh"
module tb;
import sram_host_pkg::*;
logic clk_sys = 0, reset_n = 0, reqValid = 0, retentionReq = 0;
sram_req_t reqIn = '0;
logic reqReady, readValid, retentionReady, memSelect_n, memWrite_n, memDataOe;
logic [3:0] readData, memDataOut, memQ, memDataIn;
logic [11:0] memAddr;
int n_fail = 0, compares = 0, cyc = 0;
int shadow[int];
logic [15:0] lf = 3;
assign memDataIn = memDataOe ? memDataOut : memQ;
sram_host dut(.clk_sys, .reset_n, .reqIn, .reqValid, .reqReady, .readData, .readValid, .retentionReady,
    .retentionReq, .memAddr, .memSelect_n, .memWrite_n, .memDataIn, .memDataOut, .memDataOe);
sram_model mem(.clk_sys, .memAddr, .memSelect_n, .memWrite_n, .pins(memDataIn), .memQ);
initial forever #4 clk_sys = ~clk_sys;
function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
endfunction
task check(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
        n_fail++;
        $display("unexpected %0t %s", $time, m);
    end
endtask
task results;
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
endtask
// one request, held until taken; reads compared with the shadow
task xfer(input logic w, input logic [11:0] a, input logic [3:0] d);
    int i;
    reqIn = {a, d, w};
    reqValid = 1;
    for (i = 0; i < 40 && reqReady !== 1'b1; i++) @(negedge clk_sys);
    reqValid = 0;
    check(reqReady === 1'b1, "request not taken");
    if (w) shadow[a] = d;
    else begin
        for (i = 0; i < 40 && readValid !== 1'b1; i++) @(negedge clk_sys);
        check(readValid === 1'b1 && readData === 4'(shadow[a]), "read data");
    end
    @(negedge clk_sys);
endtask
always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
        n_fail++;
        results;
    end
end
initial begin
    int k;
    repeat (5) @(negedge clk_sys);
    reset_n = 1;
    repeat (3) @(negedge clk_sys);
    xfer(1, 12'h000, 4'h5);
    xfer(1, 12'hFFF, 4'hA);
    for (k = 0; k < 40; k++) begin
        lf = nxt(lf);
        xfer(1, lf[11:0], lf[15:12]);
        xfer(0, lf[11:0], 4'h0);
    end
    xfer(0, 12'h000, 4'h0);
    retentionReq = 1;
    reqValid = 1;
    for (k = 0; k < 20 && retentionReady !== 1'b1; k++) @(negedge clk_sys);
    check(retentionReady === 1'b1 && memSelect_n === 1'b1, "no retention");
    for (k = 0; k < 12; k++) begin
        @(negedge clk_sys);
        check(reqReady === 1'b0, "taken in retention");
    end
    retentionReq = 0;
    for (k = 0; k < 20 && reqReady !== 1'b1; k++) @(negedge clk_sys);
    check(reqReady === 1'b1 && k >= `CYC_ACCESS, "access too soon after retention");
    reqValid = 0;
    for (k = 0; k < 40 && readValid !== 1'b1; k++) @(negedge clk_sys);
    check(readValid === 1'b1 && readData === 4'(shadow[0]), "read after retention");
    @(negedge clk_sys);
    xfer(0, 12'hFFF, 4'h0);
    results;
end
endmodule
